// >>> core/fpa_pkg.sv
// What this block does
// - Storing interrupt register writes its bits; unused high positions are written as ones.
// - Store panel switches copies the 28 synchronised toggles to the memory result.
// - Multiply: high product part to A, low part to B, sign in both.
// - Operand length n comes from instruction bits 26 to 22, range 0 to 27.
// - After multiply, C holds the initial A and X is cleared.
// - Multiply with n zero gives A zero, B operand, C initial A, X zero.
// - A zero multiplier or multiplicand gives a zero product whenever n is nonzero.
// - Divide puts n-bit signed quotient in A, dividend-signed remainder in B.
// - Divide sets overflow when quotient magnitude reaches one.
// - Zero or full-scale negative divisor zeroes A and B and sets overflow.
// - Zero dividend with a valid divisor gives zero quotient, overflow untouched.
// - Divide with n zero is absolute value; B kept, X cleared.
// - Double-length divide uses A and B together as the dividend.
// - Add sets carry out of the top bit and overflow past full scale.
// - Masking ANDs the operand with B; lower-half carries into bit 14 stay.
// - Upper-half immediates take operand bit 13 as the sign.
// - Subtract adds the ones complement plus one, same flags and masking.
// - Half-word add blocks the mid carry; flags come from the upper half.
// - Sum to memory writes memory and C, leaving A unchanged.
// - Sum to memory of a full-scale negative operand and a non-positive A flips the sign bit, sets overflow.
// - Difference to memory writes memory minus A to memory and C.
// - Index decrement wraps modulo two to the fourteenth and touches no indicator.
// - Normal mode with operand field all ones takes B as operand.
`default_nettype none
package fpa_pkg;
	localparam int Q_MIN_W = 14;
	localparam int Q_STEP_W = 7;
	localparam int Q_STEPS = 1;
	localparam int Q_W = Q_MIN_W + Q_STEP_W * Q_STEPS;
	localparam int MASK_BIT = 27;
	localparam int N_HI = 26;
	localparam int N_LO = 22;
	localparam int OP_HI = 21;
	localparam int OP_LO = 17;
	localparam int MODE_HI = 16;
	localparam int MODE_LO = 14;
	localparam int ST_BUSY = 0;
	localparam int ST_OVF = 1;
	localparam int ST_CARRY = 2;
	localparam int ST_MEMWR = 3;
	localparam logic [13:0] REG_OPF = 14'h3fff;
	localparam logic [27:0] FULL_NEG = 28'h800_0000;
	localparam logic [27:0] RST_WORD = 28'h000_0000;
	localparam logic [13:0] RST_IDX = 14'h0000;
	localparam logic [7:0] ADR_INSTR = 8'h00;
	localparam logic [7:0] ADR_MEMIN = 8'h04;
	localparam logic [7:0] ADR_A = 8'h08;
	localparam logic [7:0] ADR_B = 8'h0c;
	localparam logic [7:0] ADR_C = 8'h10;
	localparam logic [7:0] ADR_X = 8'h14;
	localparam logic [7:0] ADR_IDX1 = 8'h18;
	localparam logic [7:0] ADR_STATUS = 8'h24;
	localparam logic [7:0] ADR_MEMOUT = 8'h28;
	localparam logic [7:0] ADR_PC = 8'h2c;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [4:0] {
		OP_STQ = 5'h00,
		OP_STP = 5'h01,
		OP_MUL = 5'h02,
		OP_DIV = 5'h03,
		OP_ADD = 5'h04,
		OP_SUB = 5'h05,
		OP_HWA = 5'h06,
		OP_ADM = 5'h07,
		OP_SBM = 5'h08,
		OP_DIX1 = 5'h09,
		OP_DIX2 = 5'h0a,
		OP_DIX3 = 5'h0b
	} fpa_op_t;
	typedef enum logic [2:0] {
		MD_N = 3'h0,
		MD_I = 3'h1,
		MD_L = 3'h2,
		MD_U = 3'h3,
		MD_H = 3'h4
	} fpa_mode_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_EXEC = 2'h1,
		ST_WAIT = 2'h2
	} fpa_state_t;
endpackage
`default_nettype wire

// >>> core/fpa_seq_engine.sv
`timescale 1ns/100ps
`default_nettype none
module fpa_seq_engine (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic start,
	input wire logic isDiv,
	input wire logic [4:0] steps,
	input wire logic [27:0] mcand,
	input wire logic [28:0] hiInit,
	input wire logic [26:0] loInit,
	output logic done,
	output logic [28:0] hi,
	output logic [26:0] lo
);
	logic [4:0] left;
	logic [28:0] sum;
	logic [28:0] trial;
	logic fits;

	// One product or quotient bit per cycle keeps the datapath to one adder.
	assign sum = hi + (lo[0] ? {1'h0, mcand} : 29'h0000_0000);
	assign trial = {hi[27:0], lo[26]};
	assign fits = trial >= {1'h0, mcand};

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			left <= 5'h00;
			hi <= 29'h0000_0000;
			lo <= 27'h000_0000;
			done <= 1'h0;
		end else if (start) begin
			left <= steps;
			hi <= hiInit;
			lo <= loInit;
			done <= 1'h0;
		end else begin
			done <= left == 5'h01;
			if (left != 5'h00) begin
				left <= left - 5'h01;
				if (isDiv) begin
					hi <= fits ? trial - {1'h0, mcand} : trial;
					lo <= {lo[25:0], fits};
				end else begin
					hi <= {1'h0, sum[28:1]};
					lo <= {sum[0], lo[26:1]};
				end
			end
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_eng_finish: assert property (start && steps != 5'h00 |-> ##[1:28] done)
		else $error("engine did not finish in n cycles");
	a_eng_load: assert property (start |=> left == $past(steps))
		else $error("engine step count not loaded");
endmodule
`default_nettype wire

// >>> core/fpa_arith_unit.sv
`timescale 1ns/100ps
`default_nettype none
module fpa_arith_unit (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [27:0] panelSwitches,
	input wire logic [fpa_pkg::Q_W-1:0] interruptReg,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp
);
	fpa_pkg::fpa_state_t state;
	logic [27:0] instr;
	logic [27:0] memIn;
	logic [27:0] aReg;
	logic [27:0] bReg;
	logic [27:0] cReg;
	logic [13:0] xReg;
	logic [13:0] idxReg [3];
	logic [27:0] memOut;
	logic [13:0] pc;
	logic ovf;
	logic carry;
	logic memWrFlag;
	logic [27:0] swMeta;
	logic [27:0] swSync;
	logic [fpa_pkg::Q_W-1:0] qMeta;
	logic [fpa_pkg::Q_W-1:0] qSync;
	logic awHeld;
	logic wHeld;
	logic [7:0] awAddr;
	logic [31:0] wData;
	logic [3:0] wStrb;
	logic wrFire;
	logic regWr;
	logic swWr;
	logic startOp;
	logic [27:0] wVal;
	logic [3:0] clrSt;
	fpa_pkg::fpa_op_t op;
	fpa_pkg::fpa_mode_t mode;
	logic [4:0] nLen;
	logic [13:0] opf;
	logic maskEn;
	logic [27:0] eo;
	logic [27:0] eoM;
	logic [27:0] magA;
	logic [27:0] opMag;
	logic [26:0] nMask;
	logic [26:0] mulM;
	logic mulNeg;
	logic divBad;
	logic divOvf;
	logic longOp;
	logic commit;
	logic engStart;
	logic engDone;
	logic [28:0] engHi;
	logic [26:0] engLo;
	logic [26:0] quot;
	logic [27:0] addX;
	logic [27:0] addY;
	logic addCin;
	logic [28:0] addSum;
	logic addOvf;
	logic [13:0] hwLo;
	logic [14:0] hwHi;
	logic hwOvf;
	logic admFix;
	logic [27:0] next_a;
	logic [27:0] next_b;
	logic [27:0] next_c;
	logic [27:0] next_mem;
	logic ldA;
	logic ldB;
	logic ldC;
	logic ldMem;
	logic clrX;
	logic setOvf;
	logic setCarry;

	function automatic logic [27:0] absw(input logic [27:0] v);
		absw = v[27] ? 28'(-v) : v;
	endfunction

	function automatic logic addrOk(input logic [7:0] adr);
		addrOk = adr[1:0] == 2'h0 && adr <= fpa_pkg::ADR_PC;
	endfunction

	function automatic logic [27:0] rdMux(input logic [7:0] adr);
		case (adr)
			fpa_pkg::ADR_INSTR: rdMux = instr;
			fpa_pkg::ADR_MEMIN: rdMux = memIn;
			fpa_pkg::ADR_A: rdMux = aReg;
			fpa_pkg::ADR_B: rdMux = bReg;
			fpa_pkg::ADR_C: rdMux = cReg;
			fpa_pkg::ADR_X: rdMux = {14'h0000, xReg};
			fpa_pkg::ADR_IDX1: rdMux = {14'h0000, idxReg[0]};
			fpa_pkg::ADR_IDX1 + 8'h04: rdMux = {14'h0000, idxReg[1]};
			fpa_pkg::ADR_IDX1 + 8'h08: rdMux = {14'h0000, idxReg[2]};
			fpa_pkg::ADR_STATUS: rdMux = {24'h00_0000, memWrFlag, carry, ovf, state != fpa_pkg::ST_IDLE};
			fpa_pkg::ADR_MEMOUT: rdMux = memOut;
			fpa_pkg::ADR_PC: rdMux = {14'h0000, pc};
			default: rdMux = 28'h000_0000;
		endcase
	endfunction

	// Panel toggles and interrupt lines are asynchronous to ref_clk.
	always_ff @(posedge ref_clk) begin
		swMeta <= panelSwitches;
		swSync <= swMeta;
		qMeta <= interruptReg;
		qSync <= qMeta;
	end

	// Write address and data are taken independently; the write lands once both are held.
	assign s_axi_awready = !awHeld;
	assign s_axi_wready = !wHeld;
	assign s_axi_arready = !s_axi_rvalid;
	assign wrFire = awHeld && wHeld && !s_axi_bvalid;
	assign regWr = wrFire && addrOk(awAddr);
	assign swWr = regWr && state == fpa_pkg::ST_IDLE;
	assign startOp = swWr && awAddr == fpa_pkg::ADR_INSTR;
	assign clrSt = regWr && awAddr == fpa_pkg::ADR_STATUS && wStrb[0] ? wData[3:0] : 4'h0;

	always_comb begin
		wVal = rdMux(awAddr);
		for (int i = 0; i < 4; i++) begin
			if (wStrb[i]) begin
				if (i == 3) wVal[27:24] = wData[27:24];
				else wVal[i*8 +: 8] = wData[i*8 +: 8];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			awHeld <= 1'h0;
			wHeld <= 1'h0;
			awAddr <= 8'h00;
			wData <= 32'h0000_0000;
			wStrb <= 4'h0;
		end else if (wrFire) begin
			awHeld <= 1'h0;
			wHeld <= 1'h0;
		end else begin
			if (s_axi_awvalid && !awHeld) begin
				awHeld <= 1'h1;
				awAddr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !wHeld) begin
				wHeld <= 1'h1;
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_axi_bvalid <= 1'h0;
			s_axi_bresp <= fpa_pkg::RESP_OKAY;
		end else if (wrFire) begin
			s_axi_bvalid <= 1'h1;
			s_axi_bresp <= addrOk(awAddr) ? fpa_pkg::RESP_OKAY : fpa_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'h0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'h0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= fpa_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'h1;
			s_axi_rdata <= {4'h0, rdMux(s_axi_araddr)};
			s_axi_rresp <= addrOk(s_axi_araddr) ? fpa_pkg::RESP_OKAY : fpa_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'h0;
		end
	end

	assign op = fpa_pkg::fpa_op_t'(instr[fpa_pkg::OP_HI:fpa_pkg::OP_LO]);
	assign mode = fpa_pkg::fpa_mode_t'(instr[fpa_pkg::MODE_HI:fpa_pkg::MODE_LO]);
	assign nLen = instr[fpa_pkg::N_HI:fpa_pkg::N_LO];
	assign opf = instr[13:0];
	assign maskEn = instr[fpa_pkg::MASK_BIT];

	always_comb begin
		case (mode)
			fpa_pkg::MD_L: eo = {14'h0000, opf};
			fpa_pkg::MD_U: eo = {opf, 14'h0000};
			default: eo = mode == fpa_pkg::MD_N && opf == fpa_pkg::REG_OPF ? bReg : memIn;
		endcase
		eoM = maskEn ? eo & bReg : eo;
	end

	assign magA = absw(aReg);
	assign opMag = absw(eoM);
	// Lengths above 27 are outside the field's range and are treated as 27 bits wide.
	assign nMask = 27'((28'h000_0001 << nLen) - 28'h000_0001);
	assign mulM = opMag[26:0] & nMask;
	assign mulNeg = (aReg[27] ^ eoM[27]) && magA != 28'h000_0000 && mulM != 27'h000_0000;
	assign divBad = eoM == 28'h000_0000 || eoM == fpa_pkg::FULL_NEG;
	assign divOvf = magA >= opMag;
	assign longOp = nLen != 5'h00 && (op == fpa_pkg::OP_MUL || (op == fpa_pkg::OP_DIV && !divBad));
	assign engStart = state == fpa_pkg::ST_EXEC && longOp;
	assign commit = (state == fpa_pkg::ST_EXEC && !longOp) || (state == fpa_pkg::ST_WAIT && engDone);
	assign quot = engLo & nMask;

	fpa_seq_engine u_engine (
		.ref_clk(ref_clk),
		.rst(rst),
		.start(engStart),
		.isDiv(op == fpa_pkg::OP_DIV),
		.steps(nLen > 5'h1b ? 5'h1b : nLen),
		.mcand(op == fpa_pkg::OP_DIV ? opMag : magA),
		// An overflowing quotient below two loses only its top digit, taken off before the loop.
		.hiInit(op == fpa_pkg::OP_DIV ? {1'h0, divOvf ? magA - opMag : magA} : 29'h0000_0000),
		.loInit(op != fpa_pkg::OP_DIV ? mulM : mode == fpa_pkg::MD_H ? bReg[26:0] : 27'h000_0000),
		.done(engDone),
		.hi(engHi),
		.lo(engLo)
	);

	always_comb begin
		addX = aReg;
		addY = eoM;
		addCin = 1'h0;
		case (op)
			fpa_pkg::OP_SUB: begin
				addY = ~eoM;
				addCin = 1'h1;
			end
			fpa_pkg::OP_ADM: begin
				addX = eoM;
				addY = aReg;
			end
			fpa_pkg::OP_SBM: begin
				addX = eoM;
				addY = ~aReg;
				addCin = 1'h1;
			end
			default: begin
			end
		endcase
	end

	assign addSum = {1'h0, addX} + {1'h0, addY} + {28'h000_0000, addCin};
	assign addOvf = addX[27] == addY[27] && addSum[27] != addX[27];
	assign hwLo = addX[13:0] + addY[13:0];
	assign hwHi = {1'h0, addX[27:14]} + {1'h0, addY[27:14]};
	assign hwOvf = addX[27] == addY[27] && hwHi[13] != addX[27];
	assign admFix = eoM == fpa_pkg::FULL_NEG && (aReg[27] || aReg == 28'h000_0000);

	always_comb begin
		next_a = aReg;
		next_b = bReg;
		next_c = cReg;
		next_mem = memOut;
		ldA = 1'h0;
		ldB = 1'h0;
		ldC = 1'h0;
		ldMem = 1'h0;
		clrX = 1'h0;
		setOvf = 1'h0;
		setCarry = 1'h0;
		case (op)
			fpa_pkg::OP_STQ: begin
				ldMem = 1'h1;
				next_mem = {{(28 - fpa_pkg::Q_W){1'h1}}, qSync};
			end
			fpa_pkg::OP_STP: begin
				ldMem = 1'h1;
				next_mem = swSync;
			end
			fpa_pkg::OP_MUL: begin
				ldA = 1'h1;
				ldB = 1'h1;
				ldC = 1'h1;
				clrX = 1'h1;
				next_c = aReg;
				if (nLen == 5'h00) begin
					next_a = 28'h000_0000;
					next_b = eoM;
				end else if (mulNeg) begin
					next_a = engLo == 27'h000_0000 ? 28'(-engHi[27:0]) : ~engHi[27:0];
					next_b = engLo == 27'h000_0000 ? {1'h1, engLo} : {1'h1, 27'(-engLo)};
				end else begin
					next_a = engHi[27:0];
					next_b = {1'h0, engLo};
				end
			end
			fpa_pkg::OP_DIV: begin
				ldA = 1'h1;
				clrX = 1'h1;
				ldC = 1'h1;
				if (nLen == 5'h00) begin
					next_a = opMag;
					next_c = magA;
				end else if (divBad) begin
					ldB = 1'h1;
					next_a = 28'h000_0000;
					next_b = 28'h000_0000;
					next_c = opMag;
					setOvf = 1'h1;
				end else begin
					ldB = 1'h1;
					next_c = opMag;
					setOvf = divOvf;
					// A zero quotient never takes a sign, so zero dividends stay plain zero.
					next_a = (aReg[27] ^ eoM[27]) && quot != 27'h000_0000 ?
						28'(-{1'h0, quot}) : {1'h0, quot};
					next_b = aReg[27] ? 28'(-engHi[27:0]) : engHi[27:0];
				end
			end
			fpa_pkg::OP_ADD, fpa_pkg::OP_SUB: begin
				ldA = 1'h1;
				next_a = addSum[27:0];
				setOvf = addOvf;
				setCarry = addSum[28];
			end
			fpa_pkg::OP_HWA: begin
				ldA = 1'h1;
				next_a = {hwHi[13:0], hwLo};
				setOvf = hwOvf;
				setCarry = hwHi[14];
			end
			fpa_pkg::OP_ADM, fpa_pkg::OP_SBM: begin
				ldMem = 1'h1;
				ldC = 1'h1;
				next_mem = addSum[27:0];
				setCarry = addSum[28];
				setOvf = addOvf;
				if (op == fpa_pkg::OP_ADM && admFix) begin
					next_mem[27] = ~addSum[27];
					setOvf = 1'h1;
				end
				next_c = next_mem;
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state <= fpa_pkg::ST_IDLE;
		end else begin
			case (state)
				fpa_pkg::ST_IDLE: if (startOp) state <= fpa_pkg::ST_EXEC;
				fpa_pkg::ST_EXEC: state <= longOp ? fpa_pkg::ST_WAIT : fpa_pkg::ST_IDLE;
				fpa_pkg::ST_WAIT: if (engDone) state <= fpa_pkg::ST_IDLE;
				default: state <= fpa_pkg::ST_IDLE;
			endcase
		end
	end

	// Software may load working registers only while idle, so a commit never collides.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			instr <= fpa_pkg::RST_WORD;
			memIn <= fpa_pkg::RST_WORD;
			aReg <= fpa_pkg::RST_WORD;
			bReg <= fpa_pkg::RST_WORD;
			cReg <= fpa_pkg::RST_WORD;
			xReg <= fpa_pkg::RST_IDX;
		end else if (commit) begin
			if (ldA) aReg <= next_a;
			if (ldB) bReg <= next_b;
			if (ldC) cReg <= next_c;
			if (clrX) xReg <= fpa_pkg::RST_IDX;
		end else if (swWr) begin
			case (awAddr)
				fpa_pkg::ADR_INSTR: instr <= wVal;
				fpa_pkg::ADR_MEMIN: memIn <= wVal;
				fpa_pkg::ADR_A: aReg <= wVal;
				fpa_pkg::ADR_B: bReg <= wVal;
				fpa_pkg::ADR_C: cReg <= wVal;
				fpa_pkg::ADR_X: xReg <= wVal[13:0];
				default: begin
				end
			endcase
		end
	end

	for (genvar k = 0; k < 3; k++) begin : g_idx
		always_ff @(posedge ref_clk) begin
			if (rst) begin
				idxReg[k] <= fpa_pkg::RST_IDX;
			end else if (commit && op == fpa_pkg::fpa_op_t'(5'(fpa_pkg::OP_DIX1 + k))) begin
				idxReg[k] <= idxReg[k] - eoM[13:0];
			end else if (swWr && awAddr == fpa_pkg::ADR_IDX1 + 8'(4 * k)) begin
				idxReg[k] <= wVal[13:0];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pc <= fpa_pkg::RST_IDX;
			memOut <= fpa_pkg::RST_WORD;
		end else begin
			if (commit) pc <= pc + 14'h0001;
			else if (swWr && awAddr == fpa_pkg::ADR_PC) pc <= wVal[13:0];
			if (commit && ldMem) memOut <= next_mem;
		end
	end

	// Indicators are sticky; a hardware set in the same cycle as a clear wins.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ovf <= 1'h0;
			carry <= 1'h0;
			memWrFlag <= 1'h0;
		end else begin
			if (commit && setOvf) ovf <= 1'h1;
			else if (clrSt[fpa_pkg::ST_OVF]) ovf <= 1'h0;
			if (commit && setCarry) carry <= 1'h1;
			else if (clrSt[fpa_pkg::ST_CARRY]) carry <= 1'h0;
			if (commit && ldMem) memWrFlag <= 1'h1;
			else if (clrSt[fpa_pkg::ST_MEMWR]) memWrFlag <= 1'h0;
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_intr_ones: assert property (commit && op == fpa_pkg::OP_STQ |=>
		memOut[27:fpa_pkg::Q_W] == '1 && memOut[fpa_pkg::Q_W-1:0] == $past(qSync))
		else $error("stored interrupt word wrong");
	a_panel_copy: assert property (commit && op == fpa_pkg::OP_STP |=>
		memOut == $past(swSync) && memWrFlag)
		else $error("panel switches not stored");
	a_mul_regs: assert property (state == fpa_pkg::ST_WAIT && engDone && op == fpa_pkg::OP_MUL |=>
		xReg == 14'h0000 && cReg == $past(aReg) && state == fpa_pkg::ST_IDLE)
		else $error("multiply left C or X wrong");
	a_mul_zero_len: assert property (state == fpa_pkg::ST_EXEC && op == fpa_pkg::OP_MUL &&
		nLen == 5'h00 |=> aReg == 28'h000_0000 && bReg == $past(eoM))
		else $error("zero-length multiply wrong");
	a_zero_product: assert property (commit && op == fpa_pkg::OP_MUL && nLen != 5'h00 &&
		magA == 28'h000_0000 |=> aReg == 28'h000_0000 && bReg == 28'h000_0000)
		else $error("zero multiplicand gave nonzero product");
	a_div_bad: assert property (state == fpa_pkg::ST_EXEC && op == fpa_pkg::OP_DIV &&
		nLen != 5'h00 && divBad |=> aReg == 28'h000_0000 && bReg == 28'h000_0000 && ovf)
		else $error("bad divisor not handled");
	a_div_abs: assert property (state == fpa_pkg::ST_EXEC && op == fpa_pkg::OP_DIV &&
		nLen == 5'h00 |=> aReg == $past(opMag) && bReg == $past(bReg) && xReg == 14'h0000)
		else $error("absolute value divide wrong");
	a_mem_keeps_a: assert property (commit && op == fpa_pkg::OP_ADM |=>
		aReg == $past(aReg) && cReg == memOut)
		else $error("sum to memory disturbed A");
	a_idx_quiet: assert property (commit && op >= fpa_pkg::OP_DIX1 |=>
		$stable(ovf) && $stable(carry))
		else $error("index decrement touched indicators");
	a_carry_out: assert property (commit && op == fpa_pkg::OP_ADD && addSum[28] |=> carry)
		else $error("carry not set");
	a_pc_step: assert property (commit |=> pc == $past(pc) + 14'h0001)
		else $error("instruction address not advanced");

	c_mul_neg: cover property (commit && op == fpa_pkg::OP_MUL && mulNeg);
	c_div_ovf: cover property (commit && op == fpa_pkg::OP_DIV && divOvf && !divBad);
	c_adm_fix: cover property (commit && op == fpa_pkg::OP_ADM && admFix);
endmodule
`default_nettype wire

// >>> bench/fpa_core_mem.sv
`timescale 1ns/100ps
`default_nettype none
// One core memory word that keeps what the unit last stored to it.
// Parity and access timing are left out because the unit never sees them.
module fpa_core_mem (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic wrEn,
	input wire logic [27:0] wrData,
	output logic [27:0] word
);
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			word <= 28'h0;
		end else if (wrEn) begin
			word <= wrData;
		end
	end
endmodule
`default_nettype wire

// >>> bench/fixed_point_arith_unit_bench.sv
`timescale 1ns/100ps
`default_nettype none
module fixed_point_arith_unit_bench;
	localparam logic [7:0] REG_A = fpa_pkg::ADR_A;
	localparam logic [7:0] REG_B = fpa_pkg::ADR_B;
	localparam logic [7:0] REG_C = fpa_pkg::ADR_C;
	localparam logic [7:0] REG_S = fpa_pkg::ADR_STATUS;
	logic ref_clk = 1'h0, rst = 1'h1, memWr = 1'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, k;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [27:0] panelSwitches = 28'h5a5_a5a5, memData = 28'h0, memWord;
	logic [fpa_pkg::Q_W-1:0] interruptReg = 21'h1_2345;
	int badCount, checks, cyc, nOps;

	fpa_arith_unit DUT (.ref_clk, .rst, .panelSwitches, .interruptReg, .s_axi_awvalid,
		.s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
		.s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
	fpa_core_mem mem (.ref_clk, .rst, .wrEn(memWr), .wrData(memData), .word(memWord));

	initial begin
		forever #50 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			badCount++;
			giveVerdict();
		end
	end

	task automatic giveVerdict();
		if (badCount == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			badCount++;
			$display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [27:0] v);
		@(posedge ref_clk);
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_awaddr <= a;
		s_axi_wdata <= {4'h0, v};
		s_axi_bready <= 1'h1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
		@(posedge ref_clk);
		s_axi_arvalid <= 1'h1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		v = s_axi_rdata;
		e = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		logic [1:0] x;
		rd(a, v, x);
		chk(v, e);
	endtask

	function automatic logic [27:0] iw(input logic [4:0] op, input logic [2:0] md,
		input logic [4:0] n, input logic [13:0] f);
		return {1'h0, n, op, md, f};
	endfunction

	// Indicators are sticky, so every operation starts from a cleared status word.
	task automatic run(input logic [27:0] ins, input logic [27:0] a, input logic [27:0] b,
		input logic [27:0] m);
		logic [31:0] v;
		logic [1:0] x;
		wr(REG_S, 28'he);
		wr(REG_A, a);
		wr(REG_B, b);
		wr(fpa_pkg::ADR_MEMIN, m);
		wr(fpa_pkg::ADR_INSTR, ins);
		nOps++;
		for (int t = 0; t < 60; t++) begin
			rd(REG_S, v, x);
			if (v[0] === 1'h0) break;
		end
		if (v[3] === 1'h1) begin
			rd(fpa_pkg::ADR_MEMOUT, v, x);
			memData <= v[27:0];
			memWr <= 1'h1;
			@(posedge ref_clk);
			memWr <= 1'h0;
		end
		@(posedge ref_clk);
	endtask

	initial begin
		repeat (4) @(posedge ref_clk);
		rst <= 1'h0;
		rc(fpa_pkg::ADR_PC, 32'h0);
		rc(REG_S, 32'h0);
		rd(8'h30, d, r);
		chk({d[31:2], r}, {30'h0, fpa_pkg::RESP_SLVERR});
		wr(8'h30, 28'h1);
		chk({30'h0, r}, {30'h0, fpa_pkg::RESP_SLVERR});
		wr(REG_C, 28'h1);
		chk({30'h0, r}, {30'h0, fpa_pkg::RESP_OKAY});
		run(iw(5'h1, 3'h0, 5'h0, 14'h0), 28'h0, 28'h0, 28'h0);
		chk({4'h0, memWord}, 32'h05a5_a5a5);
		run(iw(5'h0, 3'h0, 5'h0, 14'h0), 28'h0, 28'h0, 28'h0);
		chk({4'h0, memWord}, 32'h0fe1_2345);
		run(iw(5'h4, 3'h0, 5'h0, 14'h0), 28'h5, 28'h0, 28'h3);
		rc(REG_A, 32'h8);
		run(iw(5'h4, 3'h2, 5'h0, 14'h1), 28'hfff_ffff, 28'h0, 28'h0);
		rc(REG_A, 32'h0);
		rc(REG_S, 32'h4);
		run(iw(5'h4, 3'h2, 5'h0, 14'h1), 28'h7ff_ffff, 28'h0, 28'h0);
		rc(REG_S, 32'h2);
		run(iw(5'h4, 3'h2, 5'h0, 14'h1), 28'h3fff, 28'h0, 28'h0);
		rc(REG_A, 32'h4000);
		run(iw(5'h4, 3'h0, 5'h0, 14'h0) | 28'h800_0000, 28'h0, 28'hf, 28'hff);
		rc(REG_A, 32'hf);
		run(iw(5'h5, 3'h2, 5'h0, 14'h5), 28'h7, 28'h0, 28'h0);
		rc(REG_A, 32'h2);
		rc(REG_S, 32'h4);
		run(iw(5'h4, 3'h3, 5'h0, 14'h3fff), 28'h0, 28'h0, 28'h0);
		rc(REG_A, 32'h0fff_c000);
		run(iw(5'h4, 3'h0, 5'h0, 14'h3fff), 28'h1, 28'h7, 28'h0);
		rc(REG_A, 32'h8);
		run(iw(5'h6, 3'h2, 5'h0, 14'h1), 28'h3fff, 28'h0, 28'h0);
		rc(REG_A, 32'h0);
		rc(REG_S, 32'h0);
		wr(fpa_pkg::ADR_X, 28'h55);
		run(iw(5'h2, 3'h0, 5'h7, 14'h0), 28'h29c, 28'h0, 28'h13);
		rc(REG_A, 32'h63);
		rc(REG_B, 32'h0140_0000);
		rc(REG_C, 32'h29c);
		rc(fpa_pkg::ADR_X, 32'h0);
		run(iw(5'h2, 3'h0, 5'h0, 14'h0), 28'h29c, 28'h0, 28'h13);
		rc(REG_A, 32'h0);
		rc(REG_B, 32'h13);
		rc(REG_C, 32'h29c);
		run(iw(5'h2, 3'h0, 5'h7, 14'h0), 28'h0, 28'h0, 28'h13);
		rc(REG_A, 32'h0);
		rc(REG_B, 32'h0);
		run(iw(5'h2, 3'h0, 5'h1b, 14'h0), 28'hfff_ffed, 28'h0, 28'h008_0000);
		rc(REG_A, 32'h0fff_ffff);
		rc(REG_B, 32'h0f68_0000);
		run(iw(5'h3, 3'h0, 5'h1b, 14'h0), 28'h5b, 28'h0, 28'ha0);
		rc(REG_A, 32'h048c_cccc);
		rc(REG_B, 32'h80);
		rc(REG_S, 32'h0);
		run(iw(5'h3, 3'h0, 5'h1b, 14'h0), 28'ha0, 28'h0, 28'h5b);
		rc(REG_S, 32'h2);
		run(iw(5'h3, 3'h0, 5'h1b, 14'h0), 28'h64, 28'h0, 28'hfff_fd80);
		rc(REG_A, 32'h0ec0_0000);
		rc(REG_B, 32'h0);
		for (k = 8'h0; k < 8'h2; k++) begin
			run(iw(5'h3, 3'h0, 5'h5, 14'h0), 28'h5, 28'h123, k[0] ? 28'h800_0000 : 28'h0);
			rc(REG_A, 32'h0);
			rc(REG_B, 32'h0);
			rc(REG_S, 32'h2);
		end
		run(iw(5'h3, 3'h0, 5'h5, 14'h0), 28'h0, 28'h0, 28'h5);
		rc(REG_A, 32'h0);
		rc(REG_S, 32'h0);
		wr(fpa_pkg::ADR_X, 28'h55);
		run(iw(5'h3, 3'h0, 5'h0, 14'h0), 28'hfff_fffb, 28'h123, 28'hfff_fffd);
		rc(REG_A, 32'h3);
		rc(REG_B, 32'h123);
		rc(REG_C, 32'h5);
		rc(fpa_pkg::ADR_X, 32'h0);
		run(iw(5'h3, 3'h4, 5'h1b, 14'h0), 28'h5b, 28'h50, 28'ha0);
		rc(REG_A, 32'h048c_cccd);
		run(iw(5'h7, 3'h0, 5'h0, 14'h0), 28'h3, 28'h0, 28'h5);
		chk({4'h0, memWord}, 32'h8);
		rc(REG_C, 32'h8);
		rc(REG_A, 32'h3);
		run(iw(5'h7, 3'h0, 5'h0, 14'h0), 28'h0, 28'h0, 28'h800_0000);
		chk({4'h0, memWord}, 32'h0);
		rc(REG_S, 32'ha);
		run(iw(5'h8, 3'h0, 5'h0, 14'h0), 28'h8, 28'h0, 28'h5);
		chk({4'h0, memWord}, 32'h0fff_fffd);
		rc(REG_C, 32'h0fff_fffd);
		rc(REG_A, 32'h8);
		for (k = 8'h0; k < 8'h3; k++) begin
			wr(fpa_pkg::ADR_IDX1 + (k << 2), 28'h2);
			run(iw(5'h9 + k[4:0], 3'h2, 5'h0, 14'h5), 28'h0, 28'h0, 28'h0);
			rc(fpa_pkg::ADR_IDX1 + (k << 2), 32'h3ffd);
			rc(REG_S, 32'h0);
		end
		rc(fpa_pkg::ADR_PC, {18'h0, nOps[13:0]});
		giveVerdict();
	end
endmodule
`default_nettype wire
